// File: core/otr_engine.sv
`timescale 1ns/1ps
module otr_engine #(
   parameter int TICK_CYC = otr_pkg::OTR_TICK_CYC,
   parameter int NUM_OUT = otr_pkg::OTR_NUM_OUT
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Output configuration write
   input wire logic i_cfg_we,
   input wire logic [6:0] i_cfg_idx,
   input wire otr_pkg::otr_cfg_type i_cfg_data,
   // Zone group membership write
   input wire logic i_grp_we,
   input wire logic [3:0] i_grp_sel,
   input wire logic [7:0] i_grp_zone,
   input wire logic i_grp_member,
   // Module enables
   input wire logic [31:0] i_dev_en,
   input wire logic [15:0] i_sup_mod,
   input wire logic [15:0] i_led_sel,
   // Event stream
   input wire logic i_evt_valid,
   input wire otr_pkg::otr_evt_type i_evt,
   output logic o_evt_ready,
   // Status and outputs
   output logic o_busy,
   output logic o_led_overflow,
   output logic [NUM_OUT-1:0] o_out
);
   import otr_pkg::*;
   localparam int IW = $clog2(NUM_OUT);

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_SCAN = 2'h2
   } otr_state_type;

   otr_cfg_type cfg_mem_reg [NUM_OUT];
   otr_cfg_type cfg_mem_next [NUM_OUT];
   logic [OTR_NUM_ZONE-1:0] grp_mem_reg [OTR_NUM_GRP];
   logic [OTR_NUM_ZONE-1:0] grp_mem_next [OTR_NUM_GRP];
   otr_state_type state_reg, state_next;
   logic [IW-1:0] idx_reg, idx_next;
   otr_evt_type evt_reg, evt_next;
   logic [OTR_NUM_ZONE-1:0] abn_reg, abn_next;
   logic [NUM_OUT-1:0] on_reg, on_next;
   logic [4:0] tmr_reg [NUM_OUT];
   logic [4:0] tmr_next [NUM_OUT];
   logic [NUM_OUT-1:0] out_reg, out_next;
   logic [NUM_OUT-1:0] legal, sup_blk;
   logic ready_reg, ready_next;
   logic busy_reg, busy_next;
   logic ovf_reg, ovf_next;
   logic tick, blink;
   otr_cfg_type cur_cfg;
   logic act_hit, deact_hit;
   logic in_act_grp, in_deact_grp, deact_grp_clear;
   logic [2:0] led_cnt;
   logic led_ok;

   // Member row of a group numbered 1..15; zero or out of range reads empty
   function automatic logic [OTR_NUM_ZONE-1:0] grp_row(input logic [3:0] g);
      logic [OTR_NUM_ZONE-1:0] row;
      row = '0;
      if (g != 4'h0 && int'(g) <= OTR_NUM_GRP) begin
         row = grp_mem_reg[4'(g - 4'h1)];
      end
      return row;
   endfunction : grp_row

   function automatic logic zone_in(input logic [OTR_NUM_ZONE-1:0] row, input logic [7:0] z);
      return (int'(z) < OTR_NUM_ZONE) && row[z];
   endfunction : zone_in

   // Whether an output's target exists, is enabled and may be driven
   function automatic logic out_legal(input otr_cfg_type c, input logic [31:0] en,
                                      input logic [15:0] sup, input logic [15:0] lsel,
                                      input logic lok);
      logic ok;
      ok = 1'b0;
      if (c.mod_led) begin
         ok = (c.mod_addr >= OTR_LED_ADDR_MIN) && (c.mod_addr <= OTR_LED_ADDR_MAX)
            && (int'(c.mod_pos) < OTR_LED_POS) && en[c.mod_addr]
            && lsel[4'(c.mod_addr - OTR_LED_ADDR_MIN)] && lok;
      end else begin
         ok = (c.mod_addr >= OTR_RLY_ADDR_MIN) && (c.mod_addr <= OTR_RLY_ADDR_MAX)
            && (int'(c.mod_pos) < OTR_RLY_POS) && en[c.mod_addr]
            && !(sup[c.mod_addr[3:0]] && c.mod_pos[0]);
      end
      return ok;
   endfunction : out_legal

   // Shared time base for momentary and pulsed behaviour
   otr_tick #(
      .TICK_CYC(TICK_CYC),
      .PULSE_TICKS(OTR_PULSE_TICKS)
   ) u_tick (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .o_tick(tick),
      .o_blink(blink)
   );

   // Group lookups for the output under scan
   always_comb begin
      cur_cfg = cfg_mem_reg[idx_reg];
      in_act_grp = zone_in(grp_row(cur_cfg.act_group), evt_reg.zone);
      in_deact_grp = zone_in(grp_row(cur_cfg.deact_group), evt_reg.zone);
      deact_grp_clear = ~|(grp_row(cur_cfg.deact_group) & abn_reg);
   end

   otr_match u_match (
      .i_cfg(cur_cfg),
      .i_evt(evt_reg),
      .i_in_act_grp(in_act_grp),
      .i_in_deact_grp(in_deact_grp),
      .i_deact_grp_clear(deact_grp_clear),
      .o_act_hit(act_hit),
      .o_deact_hit(deact_hit)
   );

   // Configuration store, one entry per output
   always_comb begin
      cfg_mem_next = cfg_mem_reg;
      if (i_cfg_we && int'(i_cfg_idx) < NUM_OUT) begin
         cfg_mem_next[i_cfg_idx[IW-1:0]] = i_cfg_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            cfg_mem_reg[i] <= OTR_CFG_RST;
         end
      end else if (i_ce) begin
         cfg_mem_reg <= cfg_mem_next;
      end
   end

   // Zone group membership, written one zone bit at a time
   always_comb begin
      grp_mem_next = grp_mem_reg;
      if (i_grp_we && i_grp_sel != 4'h0 && int'(i_grp_sel) <= OTR_NUM_GRP
          && int'(i_grp_zone) < OTR_NUM_ZONE) begin
         grp_mem_next[4'(i_grp_sel - 4'h1)][i_grp_zone] = i_grp_member;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int g = 0; g < OTR_NUM_GRP; g++) begin
            grp_mem_reg[g] <= '0;
         end
      end else if (i_ce) begin
         grp_mem_reg <= grp_mem_next;
      end
   end

   // Event intake and scan sequencer; one output judged per cycle
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      evt_next = evt_reg;
      abn_next = abn_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (i_evt_valid) begin
               evt_next = i_evt;
               state_next = ST_SCAN;
               idx_next = '0;
               // Zone state is updated before the scan, so group stops see it
               if (int'(i_evt.zone) < OTR_NUM_ZONE && i_evt.kind != OTR_EV_SYSOP) begin
                  abn_next[i_evt.zone] = (i_evt.kind != OTR_EV_RESTORE);
               end
            end
         end
         ST_SCAN: begin
            if (idx_reg == IW'(NUM_OUT - 1)) begin
               state_next = ST_IDLE;
            end else begin
               idx_next = idx_reg + IW'(1);
            end
         end
         default: state_next = ST_IDLE;
      endcase
      ready_next = (state_next == ST_IDLE);
      busy_next = (state_next == ST_SCAN);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         idx_reg <= '0;
         evt_reg <= '0;
         abn_reg <= '0;
         ready_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         evt_reg <= evt_next;
         abn_reg <= abn_next;
         ready_reg <= ready_next;
         busy_reg <= busy_next;
      end
   end

   // Output state: timers run in parallel, the scanned output is judged
   always_comb begin
      on_next = on_reg;
      tmr_next = tmr_reg;
      for (int i = 0; i < NUM_OUT; i++) begin
         if (tick && tmr_reg[i] != 5'h00) begin
            tmr_next[i] = tmr_reg[i] - 5'h01;
            if (tmr_reg[i] == 5'h01) begin
               on_next[i] = 1'b0;
            end
         end
      end
      if (state_reg == ST_SCAN) begin
         if (deact_hit) begin
            on_next[idx_reg] = 1'b0;
            tmr_next[idx_reg] = 5'h00;
         end else if (act_hit) begin
            unique case (cur_cfg.beh)
               OTR_BEH_NONE: begin
                  on_next[idx_reg] = 1'b0;
               end
               OTR_BEH_MOM: begin
                  on_next[idx_reg] = 1'b1;
                  tmr_next[idx_reg] = 5'(OTR_MOM_TICKS);
               end
               OTR_BEH_LATCH, OTR_BEH_PULSE: begin
                  on_next[idx_reg] = 1'b1;
               end
               OTR_BEH_TOGGLE: begin
                  on_next[idx_reg] = ~on_reg[idx_reg];
                  tmr_next[idx_reg] = 5'h00;
               end
               default: on_next[idx_reg] = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         on_reg <= '0;
         for (int i = 0; i < NUM_OUT; i++) begin
            tmr_reg[i] <= 5'h00;
         end
      end else if (i_ce) begin
         on_reg <= on_next;
         tmr_reg <= tmr_next;
      end
   end

   // Count enabled LED modules; beyond four, LEDs are held dark
   always_comb begin
      led_cnt = 3'h0;
      for (int a = 0; a < 16; a++) begin
         if (led_cnt != 3'h7 && i_led_sel[a] && i_dev_en[a + 8]) begin
            led_cnt = led_cnt + 3'h1;
         end
      end
      led_ok = (int'(led_cnt) <= OTR_LED_MAX_MODS);
      ovf_next = !led_ok;
   end

   // Pin drive: target check, then pulse gating (LEDs never blink)
   generate
      for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
         assign legal[k] = out_legal(cfg_mem_reg[k], i_dev_en, i_sup_mod, i_led_sel, led_ok);
         assign sup_blk[k] = !cfg_mem_reg[k].mod_led && cfg_mem_reg[k].mod_pos[0]
            && i_sup_mod[cfg_mem_reg[k].mod_addr[3:0]];
         assign out_next[k] = on_reg[k] && legal[k]
            && (cfg_mem_reg[k].beh != OTR_BEH_PULSE || cfg_mem_reg[k].mod_led || blink);
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         out_reg <= '0;
         ovf_reg <= 1'b0;
      end else if (i_ce) begin
         out_reg <= out_next;
         ovf_reg <= ovf_next;
      end
   end

   assign o_out = out_reg;
   assign o_evt_ready = ready_reg;
   assign o_busy = busy_reg;
   assign o_led_overflow = ovf_reg;

   // Helper state for checks
   logic [IW-1:0] chk_idx_reg;
   logic chk_on_reg;
   logic [NUM_OUT-1:0] chk_legal_reg, chk_sup_reg;
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         chk_idx_reg <= idx_reg;
         chk_on_reg <= on_reg[idx_reg];
         chk_legal_reg <= legal;
         chk_sup_reg <= sup_blk;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_scan_step;
      i_ce && state_reg == ST_SCAN;
   endsequence
   sequence s_scan_act;
      s_scan_step ##0 (act_hit && !deact_hit);
   endsequence

   a_stop_wins: assert property (s_scan_step ##0 deact_hit |=> !on_reg[chk_idx_reg])
      else $error("stop did not leave output off");
   a_latch_on: assert property (s_scan_act ##0 cur_cfg.beh == OTR_BEH_LATCH
      |=> on_reg[chk_idx_reg]) else $error("latched output not on");
   a_unused_off: assert property (s_scan_step ##0 cur_cfg.beh == OTR_BEH_NONE
      |=> !on_reg[chk_idx_reg]) else $error("unused output turned on");
   a_toggle_flip: assert property (s_scan_act ##0 cur_cfg.beh == OTR_BEH_TOGGLE
      |=> on_reg[chk_idx_reg] != chk_on_reg) else $error("toggle did not invert");
   a_mom_start: assert property (s_scan_act ##0 cur_cfg.beh == OTR_BEH_MOM
      |=> on_reg[chk_idx_reg] && tmr_reg[chk_idx_reg] == 5'(OTR_MOM_TICKS))
      else $error("momentary start wrong");
   a_out_gated: assert property ((o_out & ~chk_legal_reg) == '0)
      else $error("output driven on illegal target");
   a_sup_blocked: assert property ((o_out & chk_sup_reg) == '0)
      else $error("supervision relay driven");
   a_scan_start: assert property (i_ce && state_reg == ST_IDLE && i_evt_valid
      |=> state_reg == ST_SCAN && idx_reg == '0 && !o_evt_ready ##1 o_busy)
      else $error("event not scanned");
   a_scan_end: assert property (s_scan_step ##0 idx_reg == IW'(NUM_OUT - 1)
      |=> state_reg == ST_IDLE && o_evt_ready) else $error("scan did not end");
endmodule : otr_engine

// File: core/otr_match.sv
`timescale 1ns/1ps
module otr_match (
   // Configuration and event
   input wire otr_pkg::otr_cfg_type i_cfg,
   input wire otr_pkg::otr_evt_type i_evt,
   // Group lookups
   input wire logic i_in_act_grp,
   input wire logic i_in_deact_grp,
   input wire logic i_deact_grp_clear,
   // Decisions
   output logic o_act_hit,
   output logic o_deact_hit
);
   import otr_pkg::*;

   // Zero accepts any partition
   function automatic logic part_ok(input logic [1:0] want, input logic [1:0] got);
      return (want == 2'h0) || (want == got);
   endfunction : part_ok

   function automatic logic is_sysop(input logic [5:0] cat);
      return cat >= OTR_SYSOP_BASE;
   endfunction : is_sysop

   logic zone_ev;
   logic off_normal;

   // Start side
   always_comb begin
      zone_ev = (i_evt.kind != OTR_EV_SYSOP);
      off_normal = zone_ev && (i_evt.kind != OTR_EV_RESTORE);
      o_act_hit = 1'b0;
      unique case (i_cfg.act_src)
         OTR_SRC_OFF: o_act_hit = 1'b0;
         OTR_SRC_GROUP: begin
            o_act_hit = zone_ev && (i_evt.kind == i_cfg.zone_condition) && i_in_act_grp;
         end
         OTR_SRC_ZONE: begin
            o_act_hit = zone_ev && (i_evt.kind == i_cfg.zone_condition)
               && (i_evt.zone == i_cfg.act_zone);
         end
         OTR_SRC_CAT: begin
            o_act_hit = (i_evt.cat == i_cfg.act_cat) && part_ok(i_cfg.act_part, i_evt.part)
               && (is_sysop(i_cfg.act_cat) ? (i_evt.kind == OTR_EV_SYSOP)
                                           : off_normal);
         end
      endcase
   end

   // Stop side; a specific zone is not a stop source
   always_comb begin
      o_deact_hit = 1'b0;
      unique case (i_cfg.deact_src)
         OTR_SRC_OFF, OTR_SRC_ZONE: o_deact_hit = 1'b0;
         OTR_SRC_GROUP: begin
            o_deact_hit = (i_evt.kind == OTR_EV_RESTORE) && i_in_deact_grp
               && i_deact_grp_clear;
         end
         OTR_SRC_CAT: begin
            o_deact_hit = (i_evt.cat == i_cfg.deact_cat) && part_ok(i_cfg.deact_part, i_evt.part)
               && (is_sysop(i_cfg.deact_cat) ? (i_evt.kind == OTR_EV_SYSOP)
                                             : (i_evt.kind == OTR_EV_RESTORE));
         end
      endcase
   end
endmodule : otr_match

// File: core/otr_tick.sv
`timescale 1ns/1ps
module otr_tick #(
   parameter int TICK_CYC = otr_pkg::OTR_TICK_CYC,
   parameter int PULSE_TICKS = otr_pkg::OTR_PULSE_TICKS
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Time base
   output logic o_tick,
   output logic o_blink
);
   import otr_pkg::*;
   localparam int CW = $clog2(TICK_CYC + 1);
   localparam int PW = $clog2(PULSE_TICKS + 1);

   logic [CW-1:0] cnt_reg, cnt_next;
   logic [PW-1:0] pcnt_reg, pcnt_next;
   logic tick_reg, tick_next;
   logic blink_reg, blink_next;

   // Shared prescaler, so per-output timers stay five bits wide
   always_comb begin
      cnt_next = cnt_reg + CW'(1);
      tick_next = 1'b0;
      pcnt_next = pcnt_reg;
      blink_next = blink_reg;
      if (cnt_reg == CW'(TICK_CYC - 1)) begin
         cnt_next = '0;
         tick_next = 1'b1;
         pcnt_next = pcnt_reg + PW'(1);
         if (pcnt_reg == PW'(PULSE_TICKS - 1)) begin
            pcnt_next = '0;
            blink_next = ~blink_reg;
         end
      end
   end

   // Registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_reg <= '0;
         pcnt_reg <= '0;
         tick_reg <= 1'b0;
         blink_reg <= 1'b0;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
         pcnt_reg <= pcnt_next;
         tick_reg <= tick_next;
         blink_reg <= blink_next;
      end
   end

   assign o_tick = tick_reg;
   assign o_blink = blink_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_tick_single: assert property (i_ce && tick_reg |=> !tick_reg)
      else $error("tick lasted more than one enabled cycle");
endmodule : otr_tick

// File: inc/otr_pkg.sv
package otr_pkg;
   // Sizes
   localparam int OTR_NUM_OUT = 96;
   localparam int OTR_NUM_ZONE = 129;
   localparam int OTR_NUM_GRP = 15;
   localparam int OTR_LED_MAX_MODS = 4;
   localparam int OTR_RLY_POS = 4;
   localparam int OTR_LED_POS = 24;

   // Module address windows
   localparam logic [4:0] OTR_RLY_ADDR_MIN = 5'h01;
   localparam logic [4:0] OTR_RLY_ADDR_MAX = 5'h0F;
   localparam logic [4:0] OTR_LED_ADDR_MIN = 5'h08;
   localparam logic [4:0] OTR_LED_ADDR_MAX = 5'h17;

   // Category codes at or above this are system operations
   localparam logic [5:0] OTR_SYSOP_BASE = 6'h20;

   // Timing, 25 MHz clock
   localparam int OTR_CLK_NS = 40;
   localparam int OTR_TICK_MS = 100;
   localparam int OTR_TICK_CYC = OTR_TICK_MS * 1000000 / OTR_CLK_NS;
   localparam int OTR_MOM_MS = 2000;
   localparam int OTR_MOM_TICKS = OTR_MOM_MS / OTR_TICK_MS;
   localparam int OTR_PULSE_MS = 500;
   localparam int OTR_PULSE_TICKS = OTR_PULSE_MS / OTR_TICK_MS;

   typedef enum logic [2:0] {
      OTR_BEH_NONE = 3'h0,
      OTR_BEH_MOM = 3'h1,
      OTR_BEH_LATCH = 3'h2,
      OTR_BEH_PULSE = 3'h3,
      OTR_BEH_TOGGLE = 3'h4
   } otr_beh_type;

   typedef enum logic [1:0] {
      OTR_SRC_OFF = 2'h0,
      OTR_SRC_GROUP = 2'h1,
      OTR_SRC_ZONE = 2'h2,
      OTR_SRC_CAT = 2'h3
   } otr_src_type;

   typedef enum logic [2:0] {
      OTR_EV_ALARM = 3'h0,
      OTR_EV_FAULT = 3'h1,
      OTR_EV_TROUBLE = 3'h2,
      OTR_EV_RESTORE = 3'h3,
      OTR_EV_SYSOP = 3'h4
   } otr_ev_type;

   typedef struct packed {
      otr_beh_type beh;
      otr_src_type act_src;
      otr_ev_type zone_condition;
      logic [3:0] act_group;
      logic [7:0] act_zone;
      logic [5:0] act_cat;
      logic [1:0] act_part;
      otr_src_type deact_src;
      logic [3:0] deact_group;
      logic [5:0] deact_cat;
      logic [1:0] deact_part;
      logic mod_led;
      logic [4:0] mod_addr;
      logic [4:0] mod_pos;
   } otr_cfg_type;

   typedef struct packed {
      otr_ev_type kind;
      logic [7:0] zone;
      logic [5:0] cat;
      logic [1:0] part;
   } otr_evt_type;

   localparam otr_cfg_type OTR_CFG_RST = '0;
endpackage : otr_pkg

// File: tb/otr_relay_model.sv
`timescale 1ns/1ps
module otr_relay_model #(
   parameter logic [4:0] ADDR = 5'h01,
   parameter bit IS_LED = 1'b0
) (
   // Clock
   input wire logic i_clk,
   // Drive for the four positions
   input wire logic [3:0] i_drive,
   // Contact state
   output logic [3:0] o_no,
   output logic [3:0] o_nc
);
   // Switch setting outside its window means the module never answers
   localparam bit ADDR_OK = IS_LED ? (ADDR >= 5'h08 && ADDR <= 5'h17)
      : (ADDR >= 5'h01 && ADDR <= 5'h0F);
   logic [3:0] no_next;
   // Each position on its own, open contact follows the drive
   always_comb begin
      no_next = ADDR_OK ? i_drive : 4'h0;
   end
   // Changeover contacts, closed side is always the complement
   always_ff @(posedge i_clk) begin
      o_no <= no_next;
      o_nc <= ~no_next;
   end
endmodule : otr_relay_model

// File: tb/tb_otr_engine.sv
`timescale 1ns/1ps
module tb_otr_engine;
   import otr_pkg::*;
   // Stimulus and observed signals
   logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_cfg_we = 1'b0, i_grp_we = 1'b0;
   logic [6:0] i_cfg_idx = 7'h00;
   otr_cfg_type i_cfg_data = OTR_CFG_RST;
   logic [3:0] i_grp_sel = 4'h0;
   logic [7:0] i_grp_zone = 8'h00, zr;
   logic i_grp_member = 1'b0, i_evt_valid = 1'b0, o_evt_ready, o_busy, o_led_overflow;
   otr_evt_type i_evt = '0;
   logic [95:0] o_out;
   logic [3:0] r1_no, r3_no;
   logic busy_q = 1'b0, pq = 1'b0;
   logic [31:0] i_dev_en = 32'h0000000A;
   logic [15:0] i_sup_mod = 16'h0008, i_led_sel = 16'h0000;
   logic [11:0] exp_q[$];
   int n_errors = 0, check_count = 0, n, w;

   // Short tick keeps the two second hold at 80 cycles
   otr_engine #(.TICK_CYC(4), .NUM_OUT(96)) otr_engine_i (.i_clk(i_clk), .i_rst(i_rst),
      .i_ce(i_ce), .i_cfg_we(i_cfg_we), .i_cfg_idx(i_cfg_idx), .i_cfg_data(i_cfg_data),
      .i_grp_we(i_grp_we), .i_grp_sel(i_grp_sel), .i_grp_zone(i_grp_zone),
      .i_grp_member(i_grp_member), .i_dev_en(i_dev_en), .i_sup_mod(i_sup_mod),
      .i_led_sel(i_led_sel), .i_evt_valid(i_evt_valid), .i_evt(i_evt),
      .o_evt_ready(o_evt_ready), .o_busy(o_busy), .o_led_overflow(o_led_overflow),
      .o_out(o_out));
   // Far side modules at distinct addresses
   otr_relay_model #(.ADDR(5'h01)) otr_relay_model_i (.i_clk(i_clk),
      .i_drive({3'h0, o_out[0]}), .o_no(r1_no), .o_nc());
   otr_relay_model #(.ADDR(5'h03)) otr_relay_model_i3 (.i_clk(i_clk),
      .i_drive({1'b0, o_out[9], o_out[8], 1'b0}), .o_no(r3_no), .o_nc());

   initial forever #20 i_clk = ~i_clk;

   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] expv);
      check_count++;
      if (seen !== expv) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, expv, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   function automatic otr_cfg_type mk(otr_beh_type b, otr_src_type s, otr_ev_type c,
      logic [7:0] z, logic [5:0] cat, logic [1:0] p, otr_src_type ds, logic [4:0] a,
      logic [4:0] pos);
      mk = '{beh: b, act_src: s, zone_condition: c, act_group: 4'hF, act_zone: z, act_cat: cat,
         act_part: p, deact_src: ds, deact_group: 4'hF, deact_cat: cat, deact_part: 2'h0,
         mod_led: 1'b0, mod_addr: a, mod_pos: pos};
   endfunction : mk

   task automatic cfg(input logic [6:0] idx, input otr_cfg_type d, input logic g);
      @(posedge i_clk);
      i_cfg_we <= ~g;
      i_grp_we <= g;
      i_cfg_idx <= idx;
      i_cfg_data <= d;
      i_grp_sel <= 4'hF;
      i_grp_zone <= 8'(idx);
      i_grp_member <= 1'b1;
      @(posedge i_clk);
      i_cfg_we <= 1'b0;
      i_grp_we <= 1'b0;
   endtask : cfg

   // Offer one event, note the outputs expected once its scan ends
   task automatic send(otr_ev_type k, logic [7:0] z, logic [5:0] c, logic [1:0] p,
      logic [11:0] e);
      exp_q.push_back(e);
      // Ready is stale in the step of the edge that took the last event
      @(negedge i_clk);
      for (n = 0; n < 300 && o_evt_ready !== 1'b1; n++) @(negedge i_clk);
      if (n == 300) begin
         n_errors++;
         tally_and_finish();
      end
      @(posedge i_clk);
      i_evt_valid <= 1'b1;
      i_evt <= '{kind: k, zone: z, cat: c, part: p};
      @(posedge i_clk);
      i_evt_valid <= 1'b0;
   endtask : send

   // Scan end: compare low outputs, momentary bit is timed separately
   always @(negedge i_clk) begin
      busy_q <= o_busy;
      if (busy_q === 1'b1 && o_busy === 1'b0) begin
         if (exp_q.size() == 0) check("queue", 12'h000, 12'hFFF);
         else check("o_out", o_out[11:0] & 12'hFFD, exp_q.pop_front());
      end
   end

   initial begin
      w = $urandom(87956);
      zr = 8'd20 + 8'($urandom % 100);
      repeat (20) @(posedge i_clk);
      check("ready_rst", {11'h0, o_evt_ready}, 12'h000);
      i_rst <= 1'b0;
      cfg(0, mk(OTR_BEH_LATCH, OTR_SRC_ZONE, OTR_EV_ALARM, zr, 0, 0, OTR_SRC_OFF, 1, 0), 0);
      cfg(1, mk(OTR_BEH_MOM, OTR_SRC_ZONE, OTR_EV_ALARM, 5, 0, 0, OTR_SRC_OFF, 1, 1), 0);
      cfg(2, mk(OTR_BEH_TOGGLE, OTR_SRC_ZONE, OTR_EV_ALARM, 6, 0, 0, OTR_SRC_OFF, 1, 2), 0);
      cfg(3, mk(OTR_BEH_NONE, OTR_SRC_ZONE, OTR_EV_ALARM, 5, 0, 0, OTR_SRC_OFF, 1, 3), 0);
      cfg(4, mk(OTR_BEH_LATCH, OTR_SRC_GROUP, OTR_EV_ALARM, 0, 0, 0, OTR_SRC_GROUP, 1, 1), 0);
      cfg(5, mk(OTR_BEH_LATCH, OTR_SRC_CAT, OTR_EV_ALARM, 0, 3, 2, OTR_SRC_CAT, 1, 2), 0);
      cfg(6, mk(OTR_BEH_LATCH, OTR_SRC_CAT, OTR_EV_SYSOP, 0, 6'h21, 0, OTR_SRC_OFF, 1, 3), 0);
      cfg(7, mk(OTR_BEH_LATCH, OTR_SRC_ZONE, OTR_EV_ALARM, 9, 0, 0, OTR_SRC_OFF, 2, 0), 0);
      cfg(8, mk(OTR_BEH_LATCH, OTR_SRC_ZONE, OTR_EV_ALARM, 9, 0, 0, OTR_SRC_OFF, 3, 1), 0);
      cfg(9, mk(OTR_BEH_LATCH, OTR_SRC_ZONE, OTR_EV_ALARM, 9, 0, 0, OTR_SRC_OFF, 3, 2), 0);
      cfg(11, mk(OTR_BEH_LATCH, OTR_SRC_ZONE, OTR_EV_RESTORE, 8, 0, 0, OTR_SRC_GROUP, 1, 0), 0);
      cfg(12, mk(OTR_BEH_PULSE, OTR_SRC_ZONE, OTR_EV_FAULT, 10, 3, 0, OTR_SRC_CAT, 1, 1), 0);
      cfg(7, OTR_CFG_RST, 1);
      cfg(8, OTR_CFG_RST, 1);
      send(OTR_EV_ALARM, zr, 0, 0, 12'h001);
      send(OTR_EV_FAULT, zr, 0, 0, 12'h001);
      send(OTR_EV_ALARM, 5, 0, 0, 12'h001);
      for (n = 0; n < 20 && o_out[1] !== 1'b1; n++) @(negedge i_clk);
      for (w = 0; w < 200 && o_out[1] === 1'b1; w++) @(negedge i_clk);
      check("mom_width", {11'h0, w >= 75 && w <= 81}, 12'h001);
      send(OTR_EV_ALARM, 6, 0, 0, 12'h005);
      send(OTR_EV_ALARM, 6, 0, 0, 12'h001);
      send(OTR_EV_ALARM, 7, 0, 0, 12'h011);
      send(OTR_EV_ALARM, 8, 0, 0, 12'h011);
      send(OTR_EV_RESTORE, 7, 0, 0, 12'h011);
      send(OTR_EV_RESTORE, 8, 0, 0, 12'h001);
      // Pulsed relay: blink period of 40 cycles gives two or three rises
      send(OTR_EV_FAULT, 10, 0, 0, 12'h001);
      n = 0;
      for (w = 0; w < 100; w++) begin
         @(negedge i_clk);
         if (o_out[12] === 1'b1 && pq === 1'b0) n++;
         pq = o_out[12];
      end
      check("pulse_rises", {11'h0, n >= 2 && n <= 3}, 12'h001);
      send(OTR_EV_TROUBLE, 100, 3, 1, 12'h001);
      send(OTR_EV_TROUBLE, 101, 3, 2, 12'h021);
      send(OTR_EV_RESTORE, 100, 3, 1, 12'h001);
      send(OTR_EV_SYSOP, 0, 6'h21, 1, 12'h041);
      send(OTR_EV_ALARM, 9, 0, 0, 12'h241);
      repeat (120) @(negedge i_clk);
      check("relay3", {8'h0, r3_no}, 12'h004);
      check("relay1", {8'h0, r1_no}, 12'h001);
      check("upper", {11'h0, |o_out[95:12]}, 12'h000);
      check("led_ovf", {11'h0, o_led_overflow}, 12'h000);
      // Five LED modules overflow; disabling address three drops its relay
      @(posedge i_clk);
      i_dev_en <= 32'h00001F02;
      i_led_sel <= 16'h001F;
      repeat (3) @(negedge i_clk);
      check("led_ovf5", {11'h0, o_led_overflow}, 12'h001);
      check("addr_off", o_out[11:0] & 12'hFFD, 12'h041);
      check("queue_left", 12'(exp_q.size()), 12'h000);
      tally_and_finish();
   end
endmodule : tb_otr_engine
